// file: sso_pkg.sv
// Purpose: Shared constants for the servo status output logic.
// Assumes: 250 MHz core clock.
// Notes:   Channel selects use 0 for none and 1 to 3 for the three channels.
package sso_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ        = 250000000;
  localparam int unsigned MS_DIV        = CLK_HZ / 1000;
  localparam int unsigned TICK_W        = 18;
  localparam int unsigned HOLD_W        = 10;
  localparam logic [9:0]  HOLD_MIN_MS   = 10'h014;
  localparam logic [9:0]  HOLD_MAX_MS   = 10'h3E8;
  localparam logic [9:0]  HOLD_RST_MS   = 10'h014;
  localparam logic        MOTOR_OFF     = 1'h0;
  // ==========================================================
  // Output routing
  // ==========================================================
  localparam int unsigned NUM_CH        = 3;
  localparam int unsigned NUM_SRC       = 3;
  localparam logic [1:0]  SEL_NONE      = 2'h0;
  localparam int unsigned SRC_READY     = 0;
  localparam int unsigned SRC_WARN      = 1;
  localparam int unsigned SRC_POSITION_N_A      = 2;
  localparam logic        STAT_IDLE_N   = 1'h1;
  localparam logic [2:0]  CHAN_IDLE_N   = 3'h7;
  // ==========================================================
  // Code bits, active low
  // ==========================================================
  localparam logic [2:0]  CODE_IDLE_N   = 3'h7;
  localparam logic [2:0]  CODE_OVLD_N   = 3'h6;
  localparam logic [2:0]  CODE_REGEN_N  = 3'h5;
endpackage

// file: sso_hold_timer.sv
// Purpose: Momentary power-loss hold timer with millisecond tick.
// Assumes: Inputs synchronous to i_core_clk.
// Notes:   o_expired rises once main power has been off longer than the hold time.
`timescale 1ns/1ps
`default_nettype none
module sso_hold_timer (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_main_off,
  input  wire logic [9:0] i_hold_ms,
  output logic            o_expired
);
  logic [17:0] tick_reg, tick_next;
  logic [9:0]  ms_reg, ms_next;
  logic        exp_reg, exp_next;
  logic [9:0]  limit;
  logic        tick;

  // hold limit clamp.
  // Clamp the programmed hold to its legal range.
  always_comb begin
    limit = i_hold_ms;
    if (i_hold_ms < sso_pkg::HOLD_MIN_MS) begin
      limit = sso_pkg::HOLD_MIN_MS;
    end
    if (i_hold_ms > sso_pkg::HOLD_MAX_MS) begin
      limit = sso_pkg::HOLD_MAX_MS;
    end
  end

  // millisecond loss count.
  // Count whole milliseconds while power is off; restart when it returns.
  always_comb begin
    tick      = (tick_reg == 18'(sso_pkg::MS_DIV - 1));
    tick_next = tick_reg;
    ms_next   = ms_reg;
    exp_next  = exp_reg;
    if (!i_main_off) begin
      tick_next = '0;
      ms_next   = '0;
      exp_next  = 1'b0;
    end else begin
      tick_next = tick ? '0 : tick_reg + 18'h1;
      if (tick && !exp_reg) begin
        ms_next = ms_reg + 10'h1;
        // Off for longer than the hold: the motor must go off.
        if (ms_reg >= limit) begin
          exp_next = 1'b1;
        end
      end
    end
  end

  // Register the timer state.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_reg <= '0;
      ms_reg   <= '0;
      exp_reg  <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      ms_reg   <= ms_next;
      exp_reg  <= exp_next;
    end
  end

  assign o_expired = exp_reg;
endmodule
`default_nettype wire

// file: sso_status_out.sv
// Purpose: Servo ready, warning and code outputs with channel routing and power-loss hold.
// Assumes: All inputs synchronous to i_core_clk; one-cycle output latency, two cycles from main power return to o_motor_enable.
// Notes:   All status outputs are active low (low = conducting).
//          An alarm always owns the code bits; warning codes only fill them
//          when no alarm is present and the code selection allows it.
//          A main supply dip is masked at o_motor_enable only, for the programmed hold time clamped to 20 to 1000 ms; o_ready_n releases on the next edge.
`timescale 1ns/1ps
`default_nettype none
module sso_status_out (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_alarm,
  input  wire logic [2:0] i_alarm_code_n,
  input  wire logic       i_main_power_on,
  input  wire logic       i_control_power_ok,
  input  wire logic       i_undervolt_alarm,
  input  wire logic       i_abs_encoder,
  input  wire logic       i_abs_data_request,
  input  wire logic       i_abs_data_sent,
  input  wire logic       i_overload_warn,
  input  wire logic       i_regen_warn,
  input  wire logic       i_position_n_a,
  input  wire logic [1:0] i_output_select_first,
  input  wire logic [1:0] i_warning_route_field,
  input  wire logic [1:0] i_output_select_third,
  input  wire logic       i_warning_code_enable,
  input  wire logic [9:0] i_momentary_hold_time,
  output logic            o_ready_n,
  output logic            o_warn_n,
  output logic [2:0]      o_chan_n,
  output logic            o_code_bit0_n,
  output logic            o_code_bit1_n,
  output logic            o_code_bit2_n,
  output logic            o_motor_enable
);
  // ==========================================================
  // Status sources
  // ==========================================================
  logic       ready;
  logic       warn;
  logic       hold_exp;
  logic [1:0] sel [sso_pkg::NUM_SRC];
  logic [2:0] src_on;
  logic [2:0] chan_on;

  // ready condition.
  // Absolute encoder mode adds the request input and the data-sent flag.
  always_comb begin
    ready = !i_alarm && i_main_power_on;
    if (i_abs_encoder) begin
      ready = ready && i_abs_data_request && i_abs_data_sent;
    end
  end

  // warning condition.
  // Either overload kind raises the same warning level.
  assign warn = i_overload_warn || i_regen_warn;

  // per-source channel selects; position_n_a only through the third.
  // Each source has its own two-bit select; zero leaves it unrouted.
  assign sel[sso_pkg::SRC_READY] = i_output_select_first;
  assign sel[sso_pkg::SRC_WARN]  = i_warning_route_field;
  assign sel[sso_pkg::SRC_POSITION_N_A]  = i_output_select_third;
  assign src_on = {!i_position_n_a, warn, ready};

  // OR merge of every source routed to each channel.
  // A channel conducts while any source routed to it is asserted.
  genvar c;
  generate
    for (c = 0; c < sso_pkg::NUM_CH; c++) begin : g_ch
      always_comb begin
        chan_on[c] = 1'b0;
        for (int s = 0; s < sso_pkg::NUM_SRC; s++) begin
          if (sel[s] != sso_pkg::SEL_NONE && sel[s] == 2'(c + 1)) begin
            chan_on[c] = chan_on[c] | src_on[s];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Code bits
  // ==========================================================
  logic [2:0] code_n_next;
  logic [2:0] code_n_reg;

  // code selection.
  // Overload outranks regenerative overload when both are present, so
  // the host always sees at most one warning code at a time.
  always_comb begin
    code_n_next = sso_pkg::CODE_IDLE_N;
    if (i_alarm) begin
      code_n_next = i_alarm_code_n;
    end else if (i_warning_code_enable) begin
      if (i_overload_warn) begin
        code_n_next = sso_pkg::CODE_OVLD_N;
      end else if (i_regen_warn) begin
        code_n_next = sso_pkg::CODE_REGEN_N;
      end
    end
  end

  // Register the code bits; they stay released while reset is held.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      code_n_reg <= sso_pkg::CODE_IDLE_N;
    end else begin
      code_n_reg <= code_n_next;
    end
  end

  // ==========================================================
  // Power-loss hold
  // ==========================================================
  logic motor_next;
  logic motor_reg;

  // hold timer.
  // The timer only measures how long main power has been away; the
  // decision to stop the motor is made below, beside the fault cuts.
  sso_hold_timer u_hold (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_main_off (!i_main_power_on),
    .i_hold_ms  (i_momentary_hold_time),
    .o_expired  (hold_exp)
  );

  // motor enable decision.
  // A short main supply dip keeps the motor running, but an undervoltage
  // alarm or a loss of control power stops it on the next edge, whatever
  // hold time is programmed.
  always_comb begin
    motor_next = !hold_exp && i_control_power_ok && !i_undervolt_alarm;
  end

  // Register the motor enable; the motor stays off while reset is held.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      motor_reg <= sso_pkg::MOTOR_OFF;
    end else begin
      motor_reg <= motor_next;
    end
  end

  // ==========================================================
  // Ready and warning outputs
  // ==========================================================
  logic ready_n_reg;
  logic ready_n_next;
  logic warn_n_reg;
  logic warn_n_next;

  // active-low drive.
  // A low level closes the photocoupler, so an asserted status reads low.
  always_comb begin
    ready_n_next = !ready;
    warn_n_next  = !warn;
  end

  // Register ready and warning; both rest open while reset is held.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ready_n_reg <= sso_pkg::STAT_IDLE_N;
      warn_n_reg  <= sso_pkg::STAT_IDLE_N;
    end else begin
      ready_n_reg <= ready_n_next;
      warn_n_reg  <= warn_n_next;
    end
  end

  // ==========================================================
  // Channel outputs
  // ==========================================================
  logic [2:0] chan_n_reg;
  logic [2:0] chan_n_next;

  // channel drive.
  // A channel conducts, low, while any source routed to it is asserted.
  always_comb begin
    chan_n_next = ~chan_on;
  end

  // Register the channels; an unrouted channel stays open.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chan_n_reg <= sso_pkg::CHAN_IDLE_N;
    end else begin
      chan_n_reg <= chan_n_next;
    end
  end

  // ==========================================================
  // Port drive
  // ==========================================================
  // Every output comes straight from a flip-flop, so no glitch reaches a pin.
  assign o_ready_n      = ready_n_reg;
  assign o_warn_n       = warn_n_reg;
  assign o_chan_n       = chan_n_reg;
  assign o_code_bit0_n  = code_n_reg[0];
  assign o_code_bit1_n  = code_n_reg[1];
  assign o_code_bit2_n  = code_n_reg[2];
  assign o_motor_enable = motor_reg;
endmodule
`default_nettype wire

// file: sso_status_chk.sv
// Purpose: Concurrent checks on the servo status outputs.
// Assumes: Outputs lag their inputs by one clock; o_motor_enable lags main power return by two.
// Notes:   Attached to the top module by bind.
`timescale 1ns/1ps
`default_nettype none
module sso_status_chk (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_alarm,
  input wire logic [2:0] i_alarm_code_n,
  input wire logic       i_main_power_on,
  input wire logic       i_control_power_ok,
  input wire logic       i_undervolt_alarm,
  input wire logic       i_abs_encoder,
  input wire logic       i_abs_data_request,
  input wire logic       i_abs_data_sent,
  input wire logic       i_overload_warn,
  input wire logic       i_regen_warn,
  input wire logic [1:0] i_output_select_first,
  input wire logic [1:0] i_warning_route_field,
  input wire logic [1:0] i_output_select_third,
  input wire logic       i_warning_code_enable,
  input wire logic       o_ready_n,
  input wire logic       o_warn_n,
  input wire logic [2:0] o_chan_n,
  input wire logic       o_code_bit0_n,
  input wire logic       o_code_bit1_n,
  input wire logic       o_code_bit2_n,
  input wire logic       o_motor_enable
);
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Code bits gathered into one active-low word.
  wire logic [2:0] code_n = {o_code_bit2_n, o_code_bit1_n, o_code_bit0_n};
  sequence clean_s; !i_alarm && i_main_power_on; endsequence
  sequence ovl_s; !i_alarm && i_warning_code_enable && i_overload_warn; endsequence
  // Helper levels for the routing and motor checks.
  wire logic warn_any = i_overload_warn || i_regen_warn;
  wire logic aux_ok   = i_control_power_ok && !i_undervolt_alarm;
  wire logic sel_none = (i_output_select_first == 2'h0) && (i_warning_route_field == 2'h0)
                        && (i_output_select_third == 2'h0);
  sequence motor_ok_s; i_main_power_on && aux_ok; endsequence
  ready_req_a: assert property (i_abs_encoder && !i_abs_data_request |=> o_ready_n)
    else $error("ready asserted without data request");
  chan_warn_a: assert property (i_warning_route_field == 2'h3 && warn_any |=> !o_chan_n[2])
    else $error("warning not on third channel");
  chan_idle_a: assert property (sel_none |=> o_chan_n == 3'h7)
    else $error("unrouted channel driven");
  motor_dip_a: assert property ($fell(i_main_power_on) && aux_ok |=> o_motor_enable)
    else $error("motor cut at start of supply dip");
  motor_back_a: assert property (motor_ok_s ##1 motor_ok_s |=> o_motor_enable)
    else $error("motor not enabled after power return");
  ready_on_a: assert property (clean_s ##0 !i_abs_encoder |=> !o_ready_n)
    else $error("ready not asserted");
  ready_alarm_a: assert property (i_alarm |=> o_ready_n)
    else $error("ready asserted under alarm");
  ready_abs_a: assert property (i_abs_encoder && !i_abs_data_sent |=> o_ready_n)
    else $error("ready asserted before data sent");
  warn_on_a: assert property (i_overload_warn || i_regen_warn |=> !o_warn_n)
    else $error("warning not asserted");
  warn_off_a: assert property (!i_overload_warn && !i_regen_warn |=> o_warn_n)
    else $error("warning asserted without cause");
  code_alarm_a: assert property (i_alarm |=> code_n == $past(i_alarm_code_n))
    else $error("alarm code not shown");
  code_quiet_a: assert property (!i_alarm && !i_warning_code_enable |=> code_n == 3'h7)
    else $error("warning code shown while disabled");
  code_ovl_a: assert property (ovl_s |=> code_n == 3'h6)
    else $error("overload code wrong");
  motor_cut_a: assert property (i_undervolt_alarm || !i_control_power_ok |=> !o_motor_enable)
    else $error("motor kept on");
endmodule
bind sso_status_out sso_status_chk i_chk (.i_core_clk, .i_sys_rst, .i_alarm, .i_alarm_code_n,
  .i_main_power_on, .i_control_power_ok, .i_undervolt_alarm, .i_abs_encoder, .i_abs_data_request,
  .i_abs_data_sent, .i_overload_warn, .i_regen_warn, .i_output_select_first,
  .i_warning_route_field, .i_output_select_third, .i_warning_code_enable, .o_ready_n, .o_warn_n,
  .o_chan_n, .o_code_bit0_n, .o_code_bit1_n, .o_code_bit2_n, .o_motor_enable);
`default_nettype wire

// file: sso_host_model.sv
// Purpose: Host controller reading the ready and warning photocouplers.
// Assumes: Host samples on the core clock.
// Notes:   A closed, low output reads as an asserted status.
`timescale 1ns/1ps
`default_nettype none
module sso_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_ready_n,
  input  wire logic i_warn_n,
  output logic      o_ready_seen,
  output logic      o_warn_seen
);
  always_ff @(posedge i_core_clk) begin
    o_ready_seen <= !i_ready_n;
    o_warn_seen  <= !i_warn_n;
  end
endmodule
`default_nettype wire

// file: sso_status_out_bench.sv
// Purpose: Self-checking bench for the servo status output logic.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Hold expiry needs millions of cycles, so only short losses run.
`timescale 1ns/1ps
`default_nettype none
module sso_status_out_bench;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_control_power_ok = 1'b1;
  logic i_alarm = 1'b0, i_main_power_on = 1'b0, i_undervolt_alarm = 1'b0;
  logic i_abs_encoder = 1'b0, i_abs_data_request = 1'b0, i_abs_data_sent = 1'b0;
  logic i_overload_warn = 1'b0, i_regen_warn = 1'b0, i_position_n_a = 1'b1;
  logic i_warning_code_enable = 1'b0;
  logic [1:0] i_output_select_first = 2'h0, i_warning_route_field = 2'h0;
  logic [1:0] i_output_select_third = 2'h0;
  logic [2:0] i_alarm_code_n = 3'h2;
  logic [9:0] i_momentary_hold_time = sso_pkg::HOLD_RST_MS;
  logic o_ready_n, o_warn_n, o_code_bit0_n, o_code_bit1_n, o_code_bit2_n, o_motor_enable;
  logic [2:0] o_chan_n;
  logic host_ready, host_warn;
  int fail_count = 0, total_checks = 0;
  wire logic [7:0] seen = {o_ready_n, o_warn_n, o_chan_n, o_code_bit2_n, o_code_bit1_n,
                           o_code_bit0_n};
  // Rows: flags, routing and code enable, then expected status word.
  logic [22:0] rows [12] = '{{8'h41, 7'h20, 8'h77}, {8'hC1, 7'h20, 8'hFA}, {8'h71, 7'h20, 8'hFF},
    {8'h79, 7'h20, 8'h77}, {8'h69, 7'h20, 8'hFF}, {8'h45, 7'h51, 8'h2E}, {8'hC3, 7'h19, 8'h9A},
    {8'h43, 7'h08, 8'h37}, {8'h43, 7'h09, 8'h35}, {8'h00, 7'h20, 8'hFF}, {8'h00, 7'h06, 8'hDF},
    {8'h46, 7'h01, 8'h3E}};
  sso_status_out i_dut (.i_core_clk, .i_sys_rst, .i_alarm, .i_alarm_code_n, .i_main_power_on,
    .i_control_power_ok, .i_undervolt_alarm, .i_abs_encoder, .i_abs_data_request,
    .i_abs_data_sent, .i_overload_warn, .i_regen_warn, .i_position_n_a, .i_output_select_first,
    .i_warning_route_field, .i_output_select_third, .i_warning_code_enable,
    .i_momentary_hold_time, .o_ready_n, .o_warn_n, .o_chan_n, .o_code_bit0_n, .o_code_bit1_n,
    .o_code_bit2_n, .o_motor_enable);
  sso_host_model i_host (.i_core_clk, .i_ready_n(o_ready_n), .i_warn_n(o_warn_n),
    .o_ready_seen(host_ready), .o_warn_seen(host_warn));
  // Compares one value and counts the result.
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h want %h", $time, got, want);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Free-running core clock.
  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end
  // Cuts a hang short well after the tests should end.
  initial begin
    #4000;
    fail_count++;
    conclude();
  end
  // Main sequence.
  initial begin
    repeat (20) @(negedge i_core_clk);
    check(seen, 8'hFF);
    check({7'h00, o_motor_enable}, 8'h00);
    i_sys_rst = 1'b0;
    foreach (rows[k]) begin
      {i_alarm, i_main_power_on, i_abs_encoder, i_abs_data_request, i_abs_data_sent,
       i_overload_warn, i_regen_warn, i_position_n_a, i_output_select_first,
       i_warning_route_field, i_output_select_third, i_warning_code_enable} = rows[k][22:8];
      @(negedge i_core_clk);
      check(seen, rows[k][7:0]);
      check({7'h00, o_motor_enable}, 8'h01);
      @(negedge i_core_clk);
      check({6'h00, host_ready, host_warn}, {6'h00, ~rows[k][7:6]});
    end
    // Undervoltage as main power drops cuts the motor at once; control loss then keeps it off.
    i_main_power_on = 1'b0;
    i_undervolt_alarm = 1'b1;
    @(negedge i_core_clk);
    check({7'h00, o_motor_enable}, 8'h00);
    i_undervolt_alarm = 1'b0;
    i_control_power_ok = 1'b0;
    repeat (2) @(negedge i_core_clk);
    check({7'h00, o_motor_enable}, 8'h00);
    // A reset in mid-run idles every output although the inputs ask for more.
    i_control_power_ok = 1'b1;
    i_main_power_on = 1'b1;
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    check(seen, 8'hFF);
    check({7'h00, o_motor_enable}, 8'h00);
    // Released again, the outputs follow the inputs from the first edge.
    i_sys_rst = 1'b0;
    @(negedge i_core_clk);
    check(seen, 8'h3E);
    check({7'h00, o_motor_enable}, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
